// ===== verilog/nsp_consts.svh
// Offsets, field positions, reset values and fixed addresses of the block
`ifndef NSP_CONSTS_SVH
`define NSP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets on the local register port
// ----------------------------------------------------------------------
`define NSP_OFS_PFLASH_PROTECT 4'h0
`define NSP_OFS_EEPROM_PROTECT 4'h1
`define NSP_OFS_FLASH_STATUS 4'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NSP_PF_OPEN_BIT 7
`define NSP_PF_HDIS_BIT 5
`define NSP_PF_HS_HI 4
`define NSP_PF_HS_LO 3
`define NSP_EE_OPEN_BIT 7
`define NSP_EE_SIZE_HI 1
`define NSP_EE_SIZE_LO 0
`define NSP_STAT_VIOL_BIT 4
`define NSP_STAT_READY_BIT 0
`define NSP_EE_WR_MASK 8'h83

// ----------------------------------------------------------------------
// Reset values: fully protected until the configuration bytes arrive
// ----------------------------------------------------------------------
`define NSP_PF_RST 8'h7F
`define NSP_EE_RST 8'h03
`define NSP_PF_FAULT 8'h7F
`define NSP_EE_FAULT 8'h03

// ----------------------------------------------------------------------
// Global addresses and range sizes
// ----------------------------------------------------------------------
`define NSP_PF_CFG_ADDR 24'hFF_FE0C
`define NSP_EE_CFG_ADDR 24'hFF_FE0D
`define NSP_PF_HI_MIN 24'h00_0800
`define NSP_EE_BASE 24'h10_0000
`define NSP_EE_CHUNK_LAST 5'h1F

`endif

// ===== verilog/nsp_pkg.sv
// Types shared by the sector protection block
package nsp_pkg;

  // ----------------------------------------------------------------------
  // Reset-sequence loader states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    NSP_LD_PF,
    NSP_LD_EE,
    NSP_LD_DONE
  } nsp_load_t;

  // ----------------------------------------------------------------------
  // Complete state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pflash_protect;
    logic [7:0] eeprom_protect;
    logic protection_violation_flag;
    nsp_load_t ld;
    logic cfg_rd_req;
    logic [23:0] cfg_rd_addr;
    logic cmd_accept;
    logic cmd_refuse;
    logic [7:0] reg_rdata;
    logic prot_ready;
  } nsp_state_t;

endpackage

// ===== verilog/nsp_pflash_check.sv
// Program flash address range and protection decode
`timescale 1ns/100ps
`include "nsp_consts.svh"

module nsp_pflash_check #(
  parameter logic [23:0] PF_BASE = 24'hFE_0000
) (
  input wire logic [7:0] prot,
  input wire logic [23:0] addr,
  output logic in_range,
  output logic addr_prot,
  output logic any_prot
);

  logic [23:0] hi_size;
  logic [23:0] hi_start;
  logic in_hi;

  // High range always ends at the top of the address space
  always_comb begin
    hi_size = `NSP_PF_HI_MIN << prot[`NSP_PF_HS_HI:`NSP_PF_HS_LO];
    hi_start = 24'h00_0000 - hi_size;
    in_hi = (addr >= hi_start);
    in_range = (addr >= PF_BASE);
    // Open and high-disable bits pick one of four functions
    case ({prot[`NSP_PF_OPEN_BIT], prot[`NSP_PF_HDIS_BIT]})
      2'b11: addr_prot = 1'b0;
      2'b10: addr_prot = in_hi;
      2'b01: addr_prot = 1'b1;
      2'b00: addr_prot = !in_hi;
      default: addr_prot = 1'b1;
    endcase
    addr_prot = addr_prot && in_range;
    // Only the fully open setting leaves every sector writable
    any_prot = !(prot[`NSP_PF_OPEN_BIT] && prot[`NSP_PF_HDIS_BIT]);
  end

endmodule

// ===== verilog/nsp_ee_check.sv
// EEPROM address range and protection decode
`timescale 1ns/100ps
`include "nsp_consts.svh"

module nsp_ee_check #(
  parameter logic [23:0] EE_SIZE = 24'h00_0800
) (
  input wire logic [7:0] prot,
  input wire logic [23:0] addr,
  output logic in_range,
  output logic addr_prot,
  output logic any_prot
);

  logic [23:0] prot_last;

  // Protected span grows upward from the base in 32-byte steps
  always_comb begin
    prot_last = `NSP_EE_BASE +
      {17'h0_0000, prot[`NSP_EE_SIZE_HI:`NSP_EE_SIZE_LO],
       `NSP_EE_CHUNK_LAST};
    in_range = (addr >= `NSP_EE_BASE) && (addr < `NSP_EE_BASE + EE_SIZE);
    // Open bit set means size field is ignored
    addr_prot = in_range && !prot[`NSP_EE_OPEN_BIT] &&
      (addr <= prot_last);
    any_prot = !prot[`NSP_EE_OPEN_BIT];
  end

endmodule

// ===== verilog/nsp_protect.sv
// Program flash and EEPROM sector protection registers and command check
`timescale 1ns/100ps
`include "nsp_consts.svh"

module nsp_protect #(
  parameter logic [23:0] PF_BASE = 24'hFE_0000,
  parameter logic [23:0] EE_SIZE = 24'h00_0800
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic special_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic cfg_rd_req,
  output logic [23:0] cfg_rd_addr,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  input wire logic cfg_rd_dbl_fault,
  input wire logic cmd_valid,
  input wire logic cmd_erase_block,
  input wire logic [23:0] cmd_addr,
  output logic cmd_accept,
  output logic cmd_refuse,
  output logic protection_violation_flag,
  output logic prot_ready,
  output logic [7:0] pflash_protect,
  output logic [7:0] eeprom_protect
);
  import nsp_pkg::*;

  // ----------------------------------------------------------------------
  // Protection-set comparison
  // ----------------------------------------------------------------------

  // True when setting n protects at least every byte that setting o does
  function automatic logic pf_covers(input logic [7:0] o,
                                     input logic [7:0] n);
    logic [1:0] oc;
    logic [1:0] nc;
    logic [1:0] os;
    logic [1:0] ns;
    oc = {o[`NSP_PF_OPEN_BIT], o[`NSP_PF_HDIS_BIT]};
    nc = {n[`NSP_PF_OPEN_BIT], n[`NSP_PF_HDIS_BIT]};
    os = o[`NSP_PF_HS_HI:`NSP_PF_HS_LO];
    ns = n[`NSP_PF_HS_HI:`NSP_PF_HS_LO];
    case (oc)
      2'b11: pf_covers = 1'b1;
      2'b10: pf_covers = (nc == 2'b01) || (nc == 2'b10 && ns >= os);
      2'b00: pf_covers = (nc == 2'b01) || (nc == 2'b00 && ns <= os);
      2'b01: pf_covers = (nc == 2'b01);
      default: pf_covers = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State and address decode
  // ----------------------------------------------------------------------

  nsp_state_t st;
  nsp_state_t next_st;
  logic pf_in;
  logic pf_prot;
  logic pf_any;
  logic ee_in;
  logic ee_prot;
  logic ee_any;
  logic hit;
  logic ready;
  logic [7:0] pf_try;
  logic [7:0] pf_new;
  logic [7:0] ee_new;

  nsp_pflash_check #(
    .PF_BASE(PF_BASE)
  ) u_pf (
    .prot(st.pflash_protect),
    .addr(cmd_addr),
    .in_range(pf_in),
    .addr_prot(pf_prot),
    .any_prot(pf_any)
  );

  nsp_ee_check #(
    .EE_SIZE(EE_SIZE)
  ) u_ee (
    .prot(st.eeprom_protect),
    .addr(cmd_addr),
    .in_range(ee_in),
    .addr_prot(ee_prot),
    .any_prot(ee_any)
  );

  // A block erase is refused outright if the target holds any protection
  assign hit = (pf_in && (pf_prot || (cmd_erase_block && pf_any))) ||
    (ee_in && (ee_prot || (cmd_erase_block && ee_any)));
  assign ready = (st.ld == NSP_LD_DONE);

  // ----------------------------------------------------------------------
  // Candidate register values for a software write
  // ----------------------------------------------------------------------

  // Fields are tried one at a time so a reducing field cannot veto others
  always_comb begin
    pf_new = st.pflash_protect;
    pf_try = pf_new;
    if (special_mode) begin
      pf_new[`NSP_PF_OPEN_BIT] = reg_wdata[`NSP_PF_OPEN_BIT];
      pf_new[`NSP_PF_HDIS_BIT] = reg_wdata[`NSP_PF_HDIS_BIT];
      if (st.pflash_protect[`NSP_PF_HDIS_BIT]) begin
        pf_new[`NSP_PF_HS_HI:`NSP_PF_HS_LO] =
          reg_wdata[`NSP_PF_HS_HI:`NSP_PF_HS_LO];
      end
    end else begin
      pf_try[`NSP_PF_OPEN_BIT] = reg_wdata[`NSP_PF_OPEN_BIT];
      if (pf_covers(pf_new, pf_try)) begin
        pf_new = pf_try;
      end
      pf_try = pf_new;
      pf_try[`NSP_PF_HDIS_BIT] = reg_wdata[`NSP_PF_HDIS_BIT];
      if (pf_covers(pf_new, pf_try)) begin
        pf_new = pf_try;
      end
      pf_try = pf_new;
      pf_try[`NSP_PF_HS_HI:`NSP_PF_HS_LO] =
        reg_wdata[`NSP_PF_HS_HI:`NSP_PF_HS_LO];
      if (st.pflash_protect[`NSP_PF_HDIS_BIT] &&
          pf_covers(pf_new, pf_try)) begin
        pf_new = pf_try;
      end
    end
    // Reserved nonvolatile bits stay writable in both modes
    pf_new[6] = reg_wdata[6];
    pf_new[2:0] = reg_wdata[2:0];
  end

  // EEPROM: size may only grow and the open bit only drop in normal mode
  always_comb begin
    ee_new = st.eeprom_protect;
    if (special_mode) begin
      ee_new = reg_wdata & `NSP_EE_WR_MASK;
    end else begin
      if (reg_wdata[`NSP_EE_SIZE_HI:`NSP_EE_SIZE_LO] >
          st.eeprom_protect[`NSP_EE_SIZE_HI:`NSP_EE_SIZE_LO]) begin
        ee_new[`NSP_EE_SIZE_HI:`NSP_EE_SIZE_LO] =
          reg_wdata[`NSP_EE_SIZE_HI:`NSP_EE_SIZE_LO];
      end
      if (!reg_wdata[`NSP_EE_OPEN_BIT]) begin
        ee_new[`NSP_EE_OPEN_BIT] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  always_comb begin
    next_st = st;
    next_st.cmd_accept = 1'b0;
    next_st.cmd_refuse = 1'b0;
    next_st.reg_rdata = 8'h00;

    // Reset sequence fetches the two configuration bytes in turn
    case (st.ld)
      NSP_LD_PF: begin
        if (cfg_rd_valid) begin
          next_st.pflash_protect = cfg_rd_dbl_fault ?
            `NSP_PF_FAULT : cfg_rd_data;
          next_st.cfg_rd_addr = `NSP_EE_CFG_ADDR;
          next_st.ld = NSP_LD_EE;
        end
      end
      NSP_LD_EE: begin
        if (cfg_rd_valid) begin
          next_st.eeprom_protect = cfg_rd_dbl_fault ? `NSP_EE_FAULT :
            (cfg_rd_data & `NSP_EE_WR_MASK);
          next_st.cfg_rd_req = 1'b0;
          next_st.prot_ready = 1'b1;
          next_st.ld = NSP_LD_DONE;
        end
      end
      NSP_LD_DONE: begin
        next_st.cfg_rd_req = 1'b0;
        next_st.prot_ready = 1'b1;
      end
      default: begin
        next_st.ld = NSP_LD_PF;
        next_st.prot_ready = 1'b0;
        next_st.cfg_rd_req = 1'b1;
        next_st.cfg_rd_addr = `NSP_PF_CFG_ADDR;
      end
    endcase

    // Software writes; protection registers only after the load ends
    if (reg_wr) begin
      case (reg_addr)
        `NSP_OFS_PFLASH_PROTECT: begin
          if (ready) begin
            next_st.pflash_protect = pf_new;
          end
        end
        `NSP_OFS_EEPROM_PROTECT: begin
          if (ready) begin
            next_st.eeprom_protect = ee_new;
          end
        end
        `NSP_OFS_FLASH_STATUS: begin
          if (reg_wdata[`NSP_STAT_VIOL_BIT]) begin
            next_st.protection_violation_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Read data stands for one cycle only; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `NSP_OFS_PFLASH_PROTECT: next_st.reg_rdata = st.pflash_protect;
        `NSP_OFS_EEPROM_PROTECT: next_st.reg_rdata = st.eeprom_protect;
        `NSP_OFS_FLASH_STATUS: begin
          next_st.reg_rdata[`NSP_STAT_VIOL_BIT] =
            st.protection_violation_flag;
          next_st.reg_rdata[`NSP_STAT_READY_BIT] = ready;
        end
        default: next_st.reg_rdata = 8'h00;
      endcase
    end

    // Command check comes after the clear so a new hit wins over it
    if (cmd_valid) begin
      if (!ready || st.protection_violation_flag) begin
        next_st.cmd_refuse = 1'b1;
      end else if (hit) begin
        next_st.cmd_refuse = 1'b1;
        next_st.protection_violation_flag = 1'b1;
      end else begin
        next_st.cmd_accept = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset leaves both memories fully protected until the load completes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st.pflash_protect <= `NSP_PF_RST;
      st.eeprom_protect <= `NSP_EE_RST;
      st.protection_violation_flag <= 1'b0;
      st.ld <= NSP_LD_PF;
      st.cfg_rd_req <= 1'b1;
      st.cfg_rd_addr <= `NSP_PF_CFG_ADDR;
      st.cmd_accept <= 1'b0;
      st.cmd_refuse <= 1'b0;
      st.reg_rdata <= 8'h00;
      st.prot_ready <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.reg_rdata;
  assign cfg_rd_req = st.cfg_rd_req;
  assign cfg_rd_addr = st.cfg_rd_addr;
  assign cmd_accept = st.cmd_accept;
  assign cmd_refuse = st.cmd_refuse;
  assign protection_violation_flag = st.protection_violation_flag;
  assign prot_ready = st.prot_ready;
  assign pflash_protect = st.pflash_protect;
  assign eeprom_protect = st.eeprom_protect;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_pf_load_ok: assert property (
    (clk_en && st.ld == NSP_LD_PF && cfg_rd_valid && !cfg_rd_dbl_fault)
    |=> st.pflash_protect == $past(cfg_rd_data))
    else $error("flash protection not loaded from config byte");

  a_pf_load_fault: assert property (
    (clk_en && st.ld == NSP_LD_PF && cfg_rd_valid && cfg_rd_dbl_fault)
    |=> st.pflash_protect == 8'h7F && st.ld == NSP_LD_EE)
    else $error("double fault did not fully protect flash");

  a_ee_load_ok: assert property (
    (clk_en && st.ld == NSP_LD_EE && cfg_rd_valid && !cfg_rd_dbl_fault)
    |=> st.eeprom_protect == ($past(cfg_rd_data) & 8'h83) && prot_ready)
    else $error("eeprom protection not loaded from config byte");

  a_pf_no_shrink: assert property (
    (!special_mode && ready)
    |=> pf_covers($past(st.pflash_protect), st.pflash_protect))
    else $error("normal mode write reduced flash protection");

  a_hs_locked: assert property (
    (ready && !st.pflash_protect[5])
    |=> st.pflash_protect[4:3] == $past(st.pflash_protect[4:3]))
    else $error("size field changed while high disable clear");

  a_ee_open_sticky: assert property (
    (!special_mode && ready && !st.eeprom_protect[7])
    |=> !st.eeprom_protect[7] &&
        st.eeprom_protect[1:0] >= $past(st.eeprom_protect[1:0]))
    else $error("normal mode write removed eeprom protection");

  a_ee_free_write: assert property (
    (clk_en && special_mode && ready && reg_wr && reg_addr == 4'h1)
    |=> st.eeprom_protect == ($past(reg_wdata) & 8'h83))
    else $error("special mode eeprom write not applied");

  a_prot_refuse: assert property (
    (clk_en && cmd_valid && ready && !st.protection_violation_flag &&
     (pf_prot || ee_prot))
    |=> cmd_refuse && !cmd_accept && protection_violation_flag)
    else $error("protected target not refused with violation");

  a_blk_erase: assert property (
    (clk_en && cmd_valid && cmd_erase_block && ready &&
     !st.protection_violation_flag &&
     ((pf_in && pf_any) || (ee_in && ee_any)))
    |=> cmd_refuse && !cmd_accept && protection_violation_flag)
    else $error("block erase with protected sector not refused");

  a_viol_blocks: assert property (
    (clk_en && cmd_valid && st.protection_violation_flag)
    |=> cmd_refuse && !cmd_accept)
    else $error("command launched while violation flag set");

  c_load_done: cover property (st.ld == NSP_LD_EE ##[1:20] prot_ready);
  c_refused: cover property (cmd_refuse && protection_violation_flag);
  c_accepted: cover property (prot_ready ##1 cmd_accept);
  c_tighten: cover property (
    !special_mode && $changed(st.pflash_protect) && prot_ready);

endmodule

// ===== verif/nsp_cfg_model.sv
// Configuration byte source that stands in for the flash array
`timescale 1ns/100ps

module nsp_cfg_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_rd_req,
  input wire logic [23:0] cfg_rd_addr,
  input wire logic [7:0] pf_byte,
  input wire logic [7:0] ee_byte,
  input wire logic fault,
  input wire logic [3:0] delay,
  output logic cfg_rd_valid,
  output logic [7:0] cfg_rd_data,
  output logic cfg_rd_dbl_fault
);
  logic [3:0] cnt;

  // --------------------------------------------------------------------
  // Fetch engine
  // --------------------------------------------------------------------
  // Skips the cycle after a return so the advanced address is seen first;
  // between returns the data lines are inverted on every cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      cfg_rd_valid <= 1'b0;
      cfg_rd_dbl_fault <= 1'b0;
      cfg_rd_data <= 8'h00;
    end else begin
      cfg_rd_valid <= 1'b0;
      cfg_rd_dbl_fault <= 1'b0;
      cfg_rd_data <= ~cfg_rd_data;
      if (cfg_rd_req && !cfg_rd_valid) begin
        if (cnt >= delay) begin
          cnt <= 4'h0;
          cfg_rd_valid <= 1'b1;
          cfg_rd_dbl_fault <= fault;
          cfg_rd_data <= (cfg_rd_addr == 24'hFF_FE0C) ? pf_byte : ee_byte;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ===== verif/test_nvm_sector_protection.sv
// Self-checking bench for the sector protection block
`timescale 1ns/100ps

module test_nvm_sector_protection;
  logic clk_sys, sys_rst, clk_en, special_mode, reg_wr, reg_rd, keep;
  logic [3:0] reg_addr, delay;
  logic [7:0] reg_wdata, reg_rdata, pf_byte, ee_byte, cfg_rd_data;
  logic [7:0] pflash_protect, eeprom_protect;
  logic cfg_rd_req, cfg_rd_valid, cfg_rd_dbl_fault, fault;
  logic [23:0] cfg_rd_addr, cmd_addr;
  logic cmd_valid, cmd_erase_block, cmd_accept, cmd_refuse;
  logic protection_violation_flag, prot_ready;
  int mismatches, num_checks;

  // --------------------------------------------------------------------
  // Block under test and its configuration source
  // --------------------------------------------------------------------
  nsp_protect dut_u (.clk_sys, .sys_rst, .clk_en, .special_mode,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_rd_req,
    .cfg_rd_addr, .cfg_rd_valid, .cfg_rd_data, .cfg_rd_dbl_fault,
    .cmd_valid, .cmd_erase_block, .cmd_addr, .cmd_accept, .cmd_refuse,
    .protection_violation_flag, .prot_ready, .pflash_protect,
    .eeprom_protect);
  nsp_cfg_model model_u (.clk_sys, .sys_rst, .cfg_rd_req, .cfg_rd_addr,
    .pf_byte, .ee_byte, .fault, .delay, .cfg_rd_valid, .cfg_rd_data,
    .cfg_rd_dbl_fault);

  // Clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask

  // One command, its verdict, then the violation flag; clears the flag
  // afterwards unless a scenario wants it kept
  task automatic cmd(input logic [23:0] a, input logic b, input logic r,
                     input logic f);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_erase_block <= b;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1 chk("refuse", {7'h00, r}, {7'h00, cmd_refuse});
    chk("accept", {7'h00, !r}, {7'h00, cmd_accept});
    chk("flag", {7'h00, f}, {7'h00, protection_violation_flag});
    if (f && !keep) begin
      wr(4'h2, 8'h10);
    end
  endtask

  task automatic do_reset(input logic [7:0] p, input logic [7:0] e,
                          input logic f);
    int i;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    pf_byte <= p;
    ee_byte <= e;
    fault <= f;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cmd(24'hFE_0000, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 200 && prot_ready !== 1'b1; i++) @(posedge clk_sys);
    if (i == 200) begin
      mismatches++;
      final_report;
    end
    chk("pf_out", f ? 8'h7F : p, pflash_protect);
    chk("ee_out", f ? 8'h03 : e & 8'h83, eeprom_protect);
    chk("cfg_req", 8'h00, {7'h00, cfg_rd_req});
    chk("cfg_addr", 8'h0D, cfg_rd_addr[7:0]);
    rc("pf_load", 4'h0, f ? 8'h7F : p);
    rc("ee_load", 4'h1, f ? 8'h03 : e & 8'h83);
    rc("status", 4'h2, 8'h01);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_pf_normal;
    @(posedge clk_sys);
    special_mode <= 1'b0;
    wr(4'h0, 8'hFF);
    rc("pf_size", 4'h0, 8'hFF);
    wr(4'h0, 8'hDF);
    rc("pf_grow", 4'h0, 8'hDF);
    wr(4'h0, 8'hC7);
    rc("pf_size_lock", 4'h0, 8'hDF);
    wr(4'h0, 8'h5F);
    rc("pf_open", 4'h0, 8'hDF);
    wr(4'h0, 8'hF8);
    rc("pf_partial", 4'h0, 8'hD8);
    cmd(24'hFF_C000, 1'b0, 1'b1, 1'b1);
    cmd(24'hFF_BFFF, 1'b0, 1'b0, 1'b0);
    cmd(24'hFE_0000, 1'b1, 1'b1, 1'b1);
    keep = 1'b1;
    cmd(24'hFF_C000, 1'b0, 1'b1, 1'b1);
    cmd(24'hFE_0000, 1'b0, 1'b1, 1'b1);
    keep = 1'b0;
    wr(4'h2, 8'h10);
    cmd(24'hFE_0000, 1'b0, 1'b0, 1'b0);
  endtask

  // Four open/disable combinations, probed low and in the high range
  task automatic t_decode;
    logic [7:0] v [4] = '{8'hA0, 8'h80, 8'h20, 8'h00};
    @(posedge clk_sys);
    special_mode <= 1'b1;
    wr(4'h0, 8'hA0);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, v[i]);
      rc("pf_free", 4'h0, v[i]);
      cmd(24'hFE_0000, 1'b0, i > 1, i > 1);
      cmd(24'hFF_F800, 1'b0, i == 1 || i == 2, i == 1 || i == 2);
    end
  endtask

  task automatic t_sizes;
    logic [23:0] a;
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 8'hA0 | 8'(s << 3));
      wr(4'h0, 8'h80 | 8'(s << 3));
      a = 24'h00_0000 - (24'h00_0800 << s);
      cmd(a, 1'b0, 1'b1, 1'b1);
      cmd(a - 24'h00_0001, 1'b0, 1'b0, 1'b0);
    end
  endtask

  task automatic t_ee;
    for (int s = 0; s < 4; s++) begin
      wr(4'h1, 8'h7C | 8'(s));
      rc("ee_free", 4'h1, 8'(s));
      cmd(24'h10_0000 + 24'(32 * s + 31), 1'b0, 1'b1, 1'b1);
      cmd(24'h10_0000 + 24'(32 * s + 32), 1'b0, 1'b0, 1'b0);
    end
    cmd(24'h10_0080, 1'b1, 1'b1, 1'b1);
    wr(4'h1, 8'h81);
    cmd(24'h10_0000, 1'b1, 1'b0, 1'b0);
    @(posedge clk_sys);
    special_mode <= 1'b0;
    wr(4'h1, 8'h80);
    rc("ee_shrink", 4'h1, 8'h81);
    wr(4'h1, 8'h02);
    rc("ee_grow", 4'h1, 8'h02);
    wr(4'h1, 8'h81);
    rc("ee_reopen", 4'h1, 8'h02);
    // A growing write must be dropped while the clock enable is low
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(4'h1, 8'h03);
    clk_en <= 1'b1;
    rc("ee_frozen", 4'h1, 8'h02);
    wr(4'h1, 8'h03);
    rc("ee_grow_max", 4'h1, 8'h03);
  endtask

  // Top sector must be opened before the reset byte can be rewritten
  task automatic t_reprog;
    cmd(24'hFF_FE0C, 1'b0, 1'b1, 1'b1);
    @(posedge clk_sys);
    special_mode <= 1'b1;
    wr(4'h0, 8'hE7);
    rc("pf_open_all", 4'h0, 8'hFF);
    cmd(24'hFF_FE0C, 1'b0, 1'b0, 1'b0);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    special_mode = 1'b0;
    {reg_wr, reg_rd, cmd_valid, cmd_erase_block, fault, keep} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    cmd_addr = 24'h00_0000;
    pf_byte = 8'h00;
    ee_byte = 8'h00;
    delay = 4'h8;
    mismatches = 0;
    num_checks = 0;
    do_reset(8'hE7, 8'hFF, 1'b0);
    t_pf_normal;
    t_decode;
    t_sizes;
    t_ee;
    t_reprog;
    do_reset(8'hE7, 8'hFF, 1'b1);
    cmd(24'hFE_0000, 1'b0, 1'b1, 1'b1);
    final_report;
  end
endmodule
